// File: hw/icc_regs.svh
`ifndef ICC_REGS_SVH
`define ICC_REGS_SVH

// Register byte offsets
`define ICC_OFF_CTRL 12'h000
`define ICC_OFF_BUF 12'h004
`define ICC_OFF_STAT 12'h008
`define ICC_OFF_MASK 12'h00c

// Control register fields
`define ICC_MODE_LSB 0
`define ICC_BNE_BIT 3
`define ICC_OV_BIT 4
`define ICC_CPI_LSB 5
`define ICC_TSEL_BIT 7
`define ICC_IDLE_BIT 13
`define ICC_CTRL_WMASK 16'h20e7

// Reset values
`define ICC_CTRL_RST 16'h0000
`define ICC_MASK_RST 2'h0

// Event status bits
`define ICC_ST_CAP 0
`define ICC_ST_OVF 1

// Prescaler counts
`define ICC_DIV4 4'h3
`define ICC_DIV16 4'hf

`endif

// File: hw/icc_pkg.sv
package icc_pkg;
	// Capture mode field encodings
	typedef enum logic [2:0] {
		ICC_OFF = 3'b000,
		ICC_BOTH = 3'b001,
		ICC_FALL = 3'b010,
		ICC_RISE = 3'b011,
		ICC_RISE4 = 3'b100,
		ICC_RISE16 = 3'b101,
		ICC_UNUSED = 3'b110,
		ICC_WAKE = 3'b111
	} icc_mode_e;

	// Bus data phase state
	typedef enum logic [1:0] {
		ICC_BUS_IDLE = 2'b00,
		ICC_BUS_WR = 2'b01,
		ICC_BUS_RD = 2'b10
	} icc_bus_e;
endpackage

// File: hw/icc_fifo.sv
`include "icc_regs.svh"

// Capture buffer: flip-flop storage, drops pushes when full
module icc_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 4
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic flush,
	input wire logic pushValid,
	input wire logic [WIDTH-1:0] pushData,
	input wire logic popReady,
	output logic popValid,
	output logic [WIDTH-1:0] popData,
	output logic full
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [WIDTH-1:0] mem_nxt [DEPTH];
	logic [AW-1:0] wrPtr_r, wrPtr_nxt;
	logic [AW-1:0] rdPtr_r, rdPtr_nxt;
	logic [AW:0] count_r, count_nxt;
	logic doPush;
	logic doPop;

	// Wrap-around increment shared by both pointers
	function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
		if (p == AW'(DEPTH - 1)) begin
			bump = '0;
		end else begin
			bump = p + AW'(1);
		end
	endfunction

	assign popValid = (count_r != '0);
	assign full = (count_r == (AW+1)'(DEPTH));
	assign popData = mem_r[rdPtr_r];
	assign doPush = pushValid && !full;
	assign doPop = popReady && popValid;

	// Next pointer, count and storage
	always_comb begin
		mem_nxt = mem_r;
		wrPtr_nxt = wrPtr_r;
		rdPtr_nxt = rdPtr_r;
		count_nxt = count_r;
		if (flush) begin
			wrPtr_nxt = '0;
			rdPtr_nxt = '0;
			count_nxt = '0;
		end else begin
			if (doPush) begin
				mem_nxt[wrPtr_r] = pushData;
				wrPtr_nxt = bump(wrPtr_r);
			end
			if (doPop) begin
				rdPtr_nxt = bump(rdPtr_r);
			end
			count_nxt = count_r + (AW+1)'(doPush) - (AW+1)'(doPop);
		end
	end

	// Register stage
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
			count_r <= '0;
		end else begin
			wrPtr_r <= wrPtr_nxt;
			rdPtr_r <= rdPtr_nxt;
			count_r <= count_nxt;
		end
		mem_r <= mem_nxt;
	end
endmodule // icc_fifo

// File: hw/icc_channel.sv
// Notes on behaviour
// - Capture event latches selected 16-bit timer
// - Mode field selects which edges capture
// - Modes 000 and 110 disable channel
// - Mode 111: rising-edge wake interrupt only
// - Interrupt every 1 to 4 captures
// - Every-edge mode interrupts on each capture
// - Timer select 1 picks base a
// - Idle halt bit stops captures in Idle
// - Read-only overflow flag in control register
// - Read-only buffer not empty flag
// - Four-deep capture buffer, capture order
// - Capture event wakes device from Sleep/Idle
// - Up to eight channels, instantiate this each
`include "icc_regs.svh"

module icc_channel #(
	parameter int DEPTH = 4
) (
	input wire logic sys_clk,
	input wire logic rst,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [11:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Capture pin and time bases
	input wire logic capturePin,
	input wire logic [15:0] timeBaseA,
	input wire logic [15:0] timeBaseB,
	// Power state of the CPU
	input wire logic cpuIdle,
	input wire logic cpuSleep,
	// Events
	output logic irq,
	output logic wakeReq,
	output logic captureIrq
);
	timeunit 1ns;
	timeprecision 1ps;
	// Synchroniser and edge detect
	logic pinMeta_r, pinSync_r, pinPrev_r;
	logic rise, fall;
	// Control fields
	logic [2:0] modeSel_r, modeSel_nxt;
	logic [1:0] capturesPerIrq_r, capturesPerIrq_nxt;
	logic captureTimerSel_r, captureTimerSel_nxt;
	logic idleHalt_r, idleHalt_nxt;
	logic captureOverflowFlag_r, captureOverflowFlag_nxt;
	// Prescaler and per-interrupt counters
	logic [3:0] preCnt_r, preCnt_nxt;
	logic [1:0] irqCnt_r, irqCnt_nxt;
	// Event status and mask
	logic [1:0] status_r, status_nxt;
	logic [1:0] mask_r, mask_nxt;
	// Outputs as flops
	logic irq_nxt, wakeReq_nxt, captureIrq_nxt;
	// Bus data phase
	icc_pkg::icc_bus_e busSt_r, busSt_nxt;
	logic [11:0] busAddr_r, busAddr_nxt;
	logic [31:0] hrdata_nxt;
	// Capture datapath
	logic active;
	logic capEvent;
	logic doPop;
	logic fifoValid, fifoFull;
	logic [15:0] fifoData;
	logic [15:0] capValue;
	logic [15:0] ctrlView;

	// Two-flop pin synchroniser; edges are found from pinSync_r and pinPrev_r
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pinMeta_r <= 1'b0;
			pinSync_r <= 1'b0;
			pinPrev_r <= 1'b0;
		end else begin
			pinMeta_r <= capturePin;
			pinSync_r <= pinMeta_r;
			pinPrev_r <= pinSync_r;
		end
	end
	assign rise = pinSync_r && !pinPrev_r;
	assign fall = !pinSync_r && pinPrev_r;

	// Captures halt in Idle when asked to; Sleep stops the timers anyway
	assign active = !(idleHalt_r && cpuIdle);

	// Timer select: 1 picks base a
	assign capValue = captureTimerSel_r ? timeBaseA : timeBaseB;

	// Read-side view of the control register
	always_comb begin
		ctrlView = 16'h0000;
		ctrlView[`ICC_MODE_LSB +: 3] = modeSel_r;
		ctrlView[`ICC_BNE_BIT] = fifoValid;
		ctrlView[`ICC_OV_BIT] = captureOverflowFlag_r;
		ctrlView[`ICC_CPI_LSB +: 2] = capturesPerIrq_r;
		ctrlView[`ICC_TSEL_BIT] = captureTimerSel_r;
		ctrlView[`ICC_IDLE_BIT] = idleHalt_r;
	end

	// Edge qualification and prescaler
	always_comb begin
		capEvent = 1'b0;
		preCnt_nxt = preCnt_r;
		if (active) begin
			unique case (icc_pkg::icc_mode_e'(modeSel_r))
				// Plain modes hold the prescaler at zero so a later prescaled mode starts fresh
				icc_pkg::ICC_BOTH: begin
					capEvent = rise || fall;
					preCnt_nxt = 4'h0;
				end
				icc_pkg::ICC_FALL: begin
					capEvent = fall;
					preCnt_nxt = 4'h0;
				end
				icc_pkg::ICC_RISE: begin
					capEvent = rise;
					preCnt_nxt = 4'h0;
				end
				icc_pkg::ICC_RISE4: begin
					if (rise) begin
						capEvent = (preCnt_r == `ICC_DIV4);
						preCnt_nxt = capEvent ? 4'h0 : preCnt_r + 4'h1;
					end
				end
				icc_pkg::ICC_RISE16: begin
					if (rise) begin
						capEvent = (preCnt_r == `ICC_DIV16);
						preCnt_nxt = capEvent ? 4'h0 : preCnt_r + 4'h1;
					end
				end
				// Off, unused and wake-only modes never capture
				icc_pkg::ICC_OFF, icc_pkg::ICC_UNUSED, icc_pkg::ICC_WAKE: begin
					preCnt_nxt = 4'h0;
				end
			endcase
		end
	end

	// Capture buffer; full buffer refuses the push
	icc_fifo #(
		.WIDTH(16),
		.DEPTH(DEPTH)
	) icc_fifo_i (
		.sys_clk(sys_clk),
		.rst(rst),
		.flush(modeSel_r == 3'b000),
		.pushValid(capEvent),
		.pushData(capValue),
		.popReady(doPop),
		.popValid(fifoValid),
		.popData(fifoData),
		.full(fifoFull)
	);

	// AHB-Lite: address phase sampled, zero wait state data phase
	always_comb begin
		busSt_nxt = icc_pkg::ICC_BUS_IDLE;
		busAddr_nxt = busAddr_r;
		hrdata_nxt = 32'h00000000;
		doPop = 1'b0;
		if (hsel && hready && htrans[1]) begin
			busAddr_nxt = haddr;
			busSt_nxt = hwrite ? icc_pkg::ICC_BUS_WR : icc_pkg::ICC_BUS_RD;
			if (!hwrite) begin
				// Read data is registered so it stands in the data phase
				unique case (haddr)
					`ICC_OFF_CTRL: hrdata_nxt = {16'h0000, ctrlView};
					`ICC_OFF_BUF: begin
						hrdata_nxt = {16'h0000, fifoData};
						doPop = fifoValid;
					end
					`ICC_OFF_STAT: hrdata_nxt = {30'h0, status_r};
					`ICC_OFF_MASK: hrdata_nxt = {30'h0, mask_r};
					default: hrdata_nxt = 32'h00000000;
				endcase
			end
		end
	end

	// Control, status and interrupt next values
	always_comb begin
		logic wrCtrl;
		logic wrStat;
		logic wrMask;
		logic irqHit;
		logic [1:0] events;
		wrCtrl = (busSt_r == icc_pkg::ICC_BUS_WR) && (busAddr_r == `ICC_OFF_CTRL);
		wrStat = (busSt_r == icc_pkg::ICC_BUS_WR) && (busAddr_r == `ICC_OFF_STAT);
		wrMask = (busSt_r == icc_pkg::ICC_BUS_WR) && (busAddr_r == `ICC_OFF_MASK);
		irqHit = 1'b0;
		events = 2'h0;
		modeSel_nxt = modeSel_r;
		capturesPerIrq_nxt = capturesPerIrq_r;
		captureTimerSel_nxt = captureTimerSel_r;
		idleHalt_nxt = idleHalt_r;
		mask_nxt = mask_r;
		if (wrCtrl) begin
			modeSel_nxt = hwdata[`ICC_MODE_LSB +: 3];
			capturesPerIrq_nxt = hwdata[`ICC_CPI_LSB +: 2];
			captureTimerSel_nxt = hwdata[`ICC_TSEL_BIT];
			idleHalt_nxt = hwdata[`ICC_IDLE_BIT];
		end
		if (wrMask) begin
			mask_nxt = hwdata[1:0];
		end
		// Overflow: sticky until channel turned off
		captureOverflowFlag_nxt = captureOverflowFlag_r;
		if (modeSel_r == 3'b000) begin
			captureOverflowFlag_nxt = 1'b0;
		end
		if (capEvent && fifoFull) begin
			captureOverflowFlag_nxt = 1'b1;
		end
		// Captures-per-interrupt counting
		irqCnt_nxt = irqCnt_r;
		if (modeSel_r == 3'b000) begin
			irqCnt_nxt = 2'h0;
		end else if (capEvent) begin
			if (modeSel_r == 3'b001) begin
				irqHit = 1'b1;
			end else if (irqCnt_r == capturesPerIrq_r) begin
				irqHit = 1'b1;
				irqCnt_nxt = 2'h0;
			end else begin
				irqCnt_nxt = irqCnt_r + 2'h1;
			end
		end
		// Wake-only mode: rising edge in Sleep or Idle, other bits ignored
		wakeReq_nxt = 1'b0;
		if (rise && (cpuSleep || cpuIdle)) begin
			if (modeSel_r == 3'b111) begin
				wakeReq_nxt = 1'b1;
			end
		end
		if (capEvent && (cpuSleep || cpuIdle)) begin
			wakeReq_nxt = 1'b1;
		end
		captureIrq_nxt = irqHit || wakeReq_nxt;
		events = {capEvent && fifoFull, captureIrq_nxt};
		// Set wins over write-one-to-clear
		status_nxt = status_r;
		if (wrStat) begin
			status_nxt = status_r & ~hwdata[1:0];
		end
		status_nxt = status_nxt | events;
		irq_nxt = |(status_nxt & mask_nxt);
	end

	// Register stage
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			modeSel_r <= 3'(`ICC_CTRL_RST >> `ICC_MODE_LSB);
			capturesPerIrq_r <= 2'h0;
			captureTimerSel_r <= 1'b0;
			idleHalt_r <= 1'b0;
			captureOverflowFlag_r <= 1'b0;
			preCnt_r <= 4'h0;
			irqCnt_r <= 2'h0;
			status_r <= 2'h0;
			mask_r <= `ICC_MASK_RST;
			irq <= 1'b0;
			wakeReq <= 1'b0;
			captureIrq <= 1'b0;
			busSt_r <= icc_pkg::ICC_BUS_IDLE;
			busAddr_r <= 12'h000;
			hrdata <= 32'h00000000;
		end else begin
			modeSel_r <= modeSel_nxt;
			capturesPerIrq_r <= capturesPerIrq_nxt;
			captureTimerSel_r <= captureTimerSel_nxt;
			idleHalt_r <= idleHalt_nxt;
			captureOverflowFlag_r <= captureOverflowFlag_nxt;
			preCnt_r <= preCnt_nxt;
			irqCnt_r <= irqCnt_nxt;
			status_r <= status_nxt;
			mask_r <= mask_nxt;
			irq <= irq_nxt;
			wakeReq <= wakeReq_nxt;
			captureIrq <= captureIrq_nxt;
			busSt_r <= busSt_nxt;
			busAddr_r <= busAddr_nxt;
			hrdata <= hrdata_nxt;
		end
	end

	// Zero wait states, always OKAY
	always_ff @(posedge sys_clk) begin
		hreadyout <= 1'b1;
		hresp <= 1'b0;
	end
endmodule // icc_channel

// File: dv/icc_channel_chk.sv
`include "icc_regs.svh"

// Port-level checks on one capture channel
module icc_channel_chk #(
	parameter int DEPTH = 4
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [11:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic capturePin,
	input wire logic cpuIdle,
	input wire logic cpuSleep,
	input wire logic irq,
	input wire logic wakeReq,
	input wire logic captureIrq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	logic pinOld_r; // Raw pin one cycle back
	logic [3:0] pinAge_r; // Cycles since pin moved, saturating
	logic maskWr_r; // Mask write in data phase
	logic [1:0] mask_r; // Shadow of the mask register
	// Helper state, mirrors only what the ports show
	always_ff @(posedge sys_clk) begin
		pinOld_r <= capturePin;
		if (rst) begin
			pinAge_r <= 4'hf;
			maskWr_r <= 1'b0;
			mask_r <= 2'h0;
		end else begin
			pinAge_r <= (capturePin != pinOld_r) ? 4'h0 : pinAge_r + {3'h0, pinAge_r != 4'hf};
			maskWr_r <= hsel && hready && htrans[1] && hwrite && haddr == `ICC_OFF_MASK;
			if (maskWr_r) begin
				mask_r <= hwdata[1:0];
			end
		end
	end
	sequence s_rd_addr(logic [11:0] a);
		hsel && hready && htrans[1] && !hwrite && haddr == a;
	endsequence
	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("slave not ready or not okay");
	a_unmapped_zero: assert property (s_rd_addr(12'h010) |=> hrdata == 32'h0)
		else $error("unmapped read not zero");
	a_ctrl_reserved: assert property (
		s_rd_addr(`ICC_OFF_CTRL) |=> (hrdata & ~32'h0000_20ff) == 32'h0)
		else $error("reserved control bits set");
	a_wake_asleep: assert property (wakeReq |-> $past(cpuSleep) || $past(cpuIdle))
		else $error("wake while running");
	a_wake_pulse: assert property (wakeReq |=> !wakeReq)
		else $error("wake longer than a cycle");
	a_cap_pulse: assert property (captureIrq |=> !captureIrq)
		else $error("capture irq longer than a cycle");
	a_cap_cause: assert property (captureIrq |-> pinAge_r < 4'h8)
		else $error("capture irq without pin edge");
	a_wake_cause: assert property (wakeReq |-> pinAge_r < 4'h8)
		else $error("wake without pin edge");
	a_irq_masked: assert property (mask_r == 2'h0 && $past(mask_r) == 2'h0 |-> !irq)
		else $error("irq while fully masked");
endmodule // icc_channel_chk

// File: dv/icc_pulse_src.sv
// Far-side pulse source; edges land off the clock grid
module icc_pulse_src (
	output logic capturePin
);
	timeunit 1ns;
	timeprecision 1ps;
	initial capturePin = 1'b0;
	// One full pulse, long enough for the two-flop sync
	task automatic pulse();
		#3 capturePin = 1'b1;
		#40 capturePin = 1'b0;
		#37;
	endtask
endmodule // icc_pulse_src

// File: dv/input_capture_channel_test.sv
`include "icc_regs.svh"

module input_capture_channel_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk, rst, hsel, hwrite, capturePin, cpuIdle, cpuSleep;
	logic hreadyout, hresp, irq, wakeReq, captureIrq;
	logic [11:0] haddr;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] hwdata, hrdata, v;
	logic [15:0] timeBaseA, timeBaseB;
	int numErrors = 0, checkCount = 0, capCnt = 0, wakeCnt = 0;
	icc_channel icc_channel_i (.sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .capturePin(capturePin),
		.timeBaseA(timeBaseA), .timeBaseB(timeBaseB), .cpuIdle(cpuIdle), .cpuSleep(cpuSleep),
		.irq(irq), .wakeReq(wakeReq), .captureIrq(captureIrq));
	icc_pulse_src icc_pulse_src_i (.capturePin(capturePin));
	// 250 MHz system clock
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	// Event pulse counters
	always @(posedge sys_clk) begin
		if (captureIrq === 1'b1) capCnt++;
		if (wakeReq === 1'b1) wakeCnt++;
	end
	task finish_test();
		$display("Errors %0d, checks %0d", numErrors, checkCount);
		if (numErrors == 0 && checkCount > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checkCount++;
		if (seen !== exp) begin
			numErrors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Bounded wait for hready at a rising edge
	task waitReady();
		int n;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 100);
		if (hreadyout !== 1'b1) begin
			numErrors++;
			finish_test();
		end
	endtask
	// One single-word transfer, entered just after an edge
	task xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'b10;
		hwrite <= wr;
		waitReady();
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		waitReady();
		v = hrdata;
	endtask
	task rdChk(input string what, input logic [11:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		check(what, v, exp);
	endtask
	// Drains twice per pulse so the buffer never fills
	task runCase(input logic [15:0] c, input logic sl, input logic id, input int n,
		input int expCap, input int expWake);
		int c0, w0;
		xfer(1'b1, `ICC_OFF_CTRL, 32'h0);
		xfer(1'b1, `ICC_OFF_CTRL, {16'h0, c});
		cpuSleep <= sl;
		cpuIdle <= id;
		c0 = capCnt;
		w0 = wakeCnt;
		repeat (n) begin
			icc_pulse_src_i.pulse();
			@(posedge sys_clk);
			xfer(1'b0, `ICC_OFF_BUF, 32'h0);
			xfer(1'b0, `ICC_OFF_BUF, 32'h0);
		end
		repeat (8) @(posedge sys_clk);
		check("captures", capCnt - c0, expCap);
		check("wakes", wakeCnt - w0, expWake);
		cpuSleep <= 1'b0;
		cpuIdle <= 1'b0;
	endtask
	initial begin
		{rst, hsel, hwrite, cpuIdle, cpuSleep} = 5'h10;
		{haddr, htrans, hwdata, timeBaseA, timeBaseB} = '0;
		hsize = 3'h2;
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		rdChk("ctrl reset", `ICC_OFF_CTRL, 32'h0);
		rdChk("unmapped", 12'h010, 32'h0);
		xfer(1'b1, `ICC_OFF_CTRL, 32'hffff_ffff);
		rdChk("ctrl access", `ICC_OFF_CTRL, 32'h20e7);
		xfer(1'b1, `ICC_OFF_CTRL, 32'h0);
		xfer(1'b1, `ICC_OFF_CTRL, 32'h83);
		// Five captures into four places, one distinct stamp each
		for (int k = 1; k <= 5; k++) begin
			timeBaseA <= 16'(k) * 16'h1111;
			timeBaseB <= ~(16'(k) * 16'h1111);
			@(posedge sys_clk);
			icc_pulse_src_i.pulse();
			@(posedge sys_clk);
		end
		rdChk("full status", `ICC_OFF_CTRL, 32'h9b);
		for (int k = 1; k <= 4; k++) begin
			rdChk("entry", `ICC_OFF_BUF, {16'h0, 16'(k) * 16'h1111});
		end
		rdChk("drained", `ICC_OFF_CTRL, 32'h93);
		xfer(1'b1, `ICC_OFF_CTRL, 32'h0);
		xfer(1'b1, `ICC_OFF_CTRL, 32'h3);
		timeBaseB <= 16'h5a5a;
		icc_pulse_src_i.pulse();
		@(posedge sys_clk);
		rdChk("base b", `ICC_OFF_BUF, 32'h5a5a);
		rdChk("ovf clear", `ICC_OFF_CTRL, 32'h3);
		check("irq masked", {31'h0, irq}, 32'h0);
		xfer(1'b1, `ICC_OFF_MASK, 32'h1);
		repeat (2) @(posedge sys_clk);
		check("irq on", {31'h0, irq}, 32'h1);
		xfer(1'b1, `ICC_OFF_STAT, 32'h3);
		repeat (2) @(posedge sys_clk);
		check("irq off", {31'h0, irq}, 32'h0);
		rdChk("stat", `ICC_OFF_STAT, 32'h0);
		rdChk("mask", `ICC_OFF_MASK, 32'h1);
		runCase(16'h0000, 1'b0, 1'b0, 4, 0, 0);
		runCase(16'h0006, 1'b0, 1'b0, 4, 0, 0);
		runCase(16'h0001, 1'b0, 1'b0, 4, 8, 0);
		runCase(16'h0061, 1'b0, 1'b0, 4, 8, 0);
		runCase(16'h0002, 1'b0, 1'b0, 4, 4, 0);
		runCase(16'h0003, 1'b0, 1'b0, 4, 4, 0);
		runCase(16'h0004, 1'b0, 1'b0, 8, 2, 0);
		runCase(16'h0005, 1'b0, 1'b0, 16, 1, 0);
		runCase(16'h0023, 1'b0, 1'b0, 6, 3, 0);
		runCase(16'h0043, 1'b0, 1'b0, 6, 2, 0);
		runCase(16'h0063, 1'b0, 1'b0, 8, 2, 0);
		runCase(16'h0007, 1'b0, 1'b0, 4, 0, 0);
		runCase(16'h0007, 1'b1, 1'b0, 4, 4, 4);
		runCase(16'h2003, 1'b0, 1'b1, 4, 0, 0);
		runCase(16'h0003, 1'b0, 1'b1, 4, 4, 4);
		finish_test();
	end
endmodule // input_capture_channel_test

bind icc_channel icc_channel_chk #(.DEPTH(DEPTH)) icc_channel_chk_i (.sys_clk(sys_clk),
	.rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
	.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.capturePin(capturePin), .cpuIdle(cpuIdle), .cpuSleep(cpuSleep), .irq(irq),
	.wakeReq(wakeReq), .captureIrq(captureIrq));
